// ---- include/cble_pkg.sv ----
// shared constants and carrier types for the compare, branch and load/store executor
package cble_pkg;

    // ********************************
    // widths and indices
    // ********************************
    localparam int REG_W = 8;
    localparam int REG_AW = 5;
    localparam int WORD_W = 16;
    localparam int DADDR_W = 16;
    localparam int IO_AW = 5;
    localparam int BRANCH_OFFS_W = 7;
    localparam int DISP_W = 6;
    localparam logic [REG_W-1:0] STATUS_RESET = 8'h00;

    // status flag bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;

    // pointer pairs, low byte index; high byte is the next register
    localparam logic [REG_AW-1:0] PTR_X = 5'h1A;
    localparam logic [REG_AW-1:0] PTR_Y = 5'h1C;
    localparam logic [REG_AW-1:0] PTR_Z = 5'h1E;

    // ********************************
    // opcode masks and match values
    // ********************************
    localparam logic [WORD_W-1:0] MSK_ALU = 16'hFC00;
    localparam logic [WORD_W-1:0] VAL_CP = 16'h1400;
    localparam logic [WORD_W-1:0] VAL_CPC = 16'h0400;
    localparam logic [WORD_W-1:0] VAL_MOV = 16'h2C00;
    localparam logic [WORD_W-1:0] MSK_IMM = 16'hF000;
    localparam logic [WORD_W-1:0] VAL_CPI = 16'h3000;
    localparam logic [WORD_W-1:0] VAL_LDI = 16'hE000;
    localparam logic [WORD_W-1:0] MSK_PAIR = 16'hFF00;
    localparam logic [WORD_W-1:0] VAL_COPY_REG_PAIR = 16'h0100;
    localparam logic [WORD_W-1:0] VAL_SKIC = 16'h9900;
    localparam logic [WORD_W-1:0] VAL_SKIS = 16'h9B00;
    localparam logic [WORD_W-1:0] MSK_SKR = 16'hFE08;
    localparam logic [WORD_W-1:0] VAL_SKRC = 16'hFC00;
    localparam logic [WORD_W-1:0] VAL_SKRS = 16'hFE00;
    localparam logic [WORD_W-1:0] VAL_BRS = 16'hF000;
    localparam logic [WORD_W-1:0] VAL_BRC = 16'hF400;
    localparam logic [WORD_W-1:0] MSK_LDST = 16'hFE00;
    localparam logic [WORD_W-1:0] VAL_LDG = 16'h9000;
    localparam logic [WORD_W-1:0] VAL_STG = 16'h9200;
    localparam logic [WORD_W-1:0] MSK_LDD = 16'hD200;
    localparam logic [WORD_W-1:0] VAL_LDD = 16'h8000;

    // low nibble of the indirect load/store group
    localparam logic [3:0] NIB_DIRECT = 4'h0;
    localparam logic [3:0] NIB_ZI = 4'h1;
    localparam logic [3:0] NIB_ZD = 4'h2;
    localparam logic [3:0] NIB_YI = 4'h9;
    localparam logic [3:0] NIB_YD = 4'hA;
    localparam logic [3:0] NIB_X = 4'hC;
    localparam logic [3:0] NIB_XI = 4'hD;
    localparam logic [3:0] NIB_XD = 4'hE;

    // ********************************
    // types
    // ********************************
    typedef enum logic [3:0] {
        OP_NOP, OP_CP, OP_CPC, OP_CPI, OP_MOV, OP_COPY_REG_PAIR, OP_LDI, OP_SKRC,
        OP_SKRS, OP_SKIC, OP_SKIS, OP_BRS, OP_BRC, OP_LD, OP_ST
    } cble_op_t;

    typedef enum logic [2:0] {PM_PLAIN, PM_INC, PM_DEC, PM_DISP, PM_DIRECT} cble_pmode_t;

    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic [WORD_W-1:0] ext;
        logic next_two_word;
    } cble_fetch_t;

    typedef struct packed {
        cble_op_t op;
        cble_pmode_t pmode;
        logic [REG_AW-1:0] rd;
        logic [REG_AW-1:0] rr;
        logic [REG_W-1:0] imm;
        logic [2:0] bsel;
        logic [BRANCH_OFFS_W-1:0] offs;
        logic [DISP_W-1:0] disp;
        logic [DADDR_W-1:0] addr;
        logic two_word;
        logic skip_two;
    } cble_dec_t;

    typedef struct packed {
        logic [DADDR_W-1:0] addr;
        logic [REG_W-1:0] wdata;
        logic we;
        logic re;
    } cble_dmem_req_t;

endpackage

// ---- hw/cble_regfile.sv ----
// working register file: three registered read ports, two write ports
`timescale 1ns/100ps
module cble_regfile #(
    parameter int DEPTH = 32,
    parameter int DATA_W = 8,
    parameter int AW = 5
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rd_en,
    input wire logic [AW-1:0] ra_addr,
    input wire logic [AW-1:0] rb_addr,
    input wire logic [AW-1:0] rc_addr,
    output logic [DATA_W-1:0] ra_data,
    output logic [DATA_W-1:0] rb_data,
    output logic [DATA_W-1:0] rc_data,
    input wire logic w0_en,
    input wire logic [AW-1:0] w0_addr,
    input wire logic [DATA_W-1:0] w0_data,
    input wire logic w1_en,
    input wire logic [AW-1:0] w1_addr,
    input wire logic [DATA_W-1:0] w1_data
);
    logic [DATA_W-1:0] mem [DEPTH];

    // a read in the same edge as a write sees the new value, so back to back
    // instructions need no forwarding in the core
    function automatic logic [DATA_W-1:0] rd_byp(input logic [AW-1:0] a);
        logic [DATA_W-1:0] v;
        v = mem[a];
        if (w1_en && w1_addr == a) begin
            v = w1_data;
        end
        if (w0_en && w0_addr == a) begin
            v = w0_data;
        end
        return v;
    endfunction

    always_ff @(posedge mclk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (w0_en && w0_addr == AW'(i)) begin
                mem[i] <= w0_data;
            end else if (w1_en && w1_addr == AW'(i)) begin
                mem[i] <= w1_data;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ra_data <= '0;
            rb_data <= '0;
            rc_data <= '0;
        end else if (rd_en) begin
            ra_data <= rd_byp(ra_addr);
            rb_data <= rd_byp(rb_addr);
            rc_data <= rd_byp(rc_addr);
        end
    end
endmodule // cble_regfile

// ---- hw/cble_core.sv ----
// compare, skip, branch, move and data load/store executor of an 8-bit core
// Overview of operation
// - compares subtract without result, update Z N V C H, one clock.
// - skip when tested working-register bit is zero; pc plus 2 or 3.
// - skip when tested working-register bit is one; flags untouched, 1/2/3 clocks.
// - skip when addressed I/O register bit is zero; 1/2/3 clocks, no flags.
// - skip when addressed I/O register bit is one; 1/2/3 clocks, no flags.
// - branch when selected status bit is one: pc plus offset plus one.
// - branch when selected status bit is zero; one or two clocks.
// - signed greater-or-equal branch taken when N xor V is zero.
// - signed less-than branch taken when N xor V is one.
// - half-carry branches taken on H one or H zero.
// - transfer-bit branches taken on T one or T zero.
// - overflow branch taken when V is one.
// - carry-clear and same-or-higher on C zero; carry-set and lower on C one.
// - indirect loads through X, Y, Z take 2 clocks; post-increment bumps pointer.
// - pre-decrement load lowers pointer first, then reads new address.
// - displacement loads via Y or Z read pointer plus q, pointer unchanged.
// - direct load reads absolute address from second word in two clocks.
// - indirect store through X writes source in 2 clocks; post-increment bumps X.
`timescale 1ns/100ps
module cble_core #(
    parameter int PC_W = 16,
    parameter logic [PC_W-1:0] PC_RESET = '0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire cble_pkg::cble_fetch_t instr,
    output logic instr_ready,
    output logic [PC_W-1:0] pc,
    output logic [cble_pkg::REG_W-1:0] status_flags,
    output logic [cble_pkg::IO_AW-1:0] io_addr,
    input wire logic [cble_pkg::REG_W-1:0] io_rdata,
    output cble_pkg::cble_dmem_req_t dmem_req,
    input wire logic [cble_pkg::REG_W-1:0] dmem_rdata
);
    import cble_pkg::*;

    // ********************************
    // declarations
    // ********************************
    typedef enum {ST_RUN, ST_WAIT, ST_MEM} cble_state_t;

    cble_state_t state_reg;
    logic [1:0] wait_cnt_reg;
    logic exec_valid_reg;
    cble_dec_t exec_reg;
    cble_dec_t dec_next;
    logic [PC_W-1:0] pc_reg;
    logic [REG_W-1:0] status_flags_reg;
    logic [IO_AW-1:0] io_addr_reg;
    cble_dmem_req_t dmem_reg;
    logic accept, fire, test_bit, br_taken, skip_taken, is_mem;
    logic [REG_AW-1:0] ra_addr, rb_addr, rc_addr;
    logic [REG_W-1:0] ra_data, rb_data, rc_data;
    logic w0_en, w1_en;
    logic [REG_AW-1:0] w0_addr, w1_addr;
    logic [REG_W-1:0] w0_data, w1_data;
    logic [DADDR_W-1:0] ptr, ptr_inc, ptr_dec, eff_addr;

    // ********************************
    // functions
    // ********************************
    function automatic logic hit(input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] m,
                                 input logic [WORD_W-1:0] v);
        return (w & m) == v;
    endfunction

    // subtraction flags; zchain keeps Z only if it was already set (with-carry form)
    function automatic logic [REG_W-1:0] cmp_flags(input logic [REG_W-1:0] a, input logic [REG_W-1:0] b,
                                                   input logic cin, input logic zchain,
                                                   input logic [REG_W-1:0] sr);
        logic [REG_W-1:0] r;
        logic [REG_W-1:0] f;
        r = a - b - {7'h00, cin};
        f = sr;
        f[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        f[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        f[FLAG_N] = r[7];
        f[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        f[FLAG_Z] = (r == 8'h00) & (~zchain | sr[FLAG_Z]);
        return f;
    endfunction

    function automatic cble_dec_t decode(input cble_fetch_t f);
        cble_dec_t d;
        d = '0;
        d.op = OP_NOP;
        d.pmode = PM_PLAIN;
        d.rd = f.word[8:4];
        d.rr = {f.word[9], f.word[3:0]};
        d.imm = {f.word[11:8], f.word[3:0]};
        d.bsel = f.word[2:0];
        d.offs = f.word[9:3];
        d.disp = {f.word[13], f.word[11:10], f.word[2:0]};
        d.addr = f.ext;
        d.skip_two = f.next_two_word;
        if (hit(f.word, MSK_ALU, VAL_CP)) begin
            d.op = OP_CP;
        end else if (hit(f.word, MSK_ALU, VAL_CPC)) begin
            d.op = OP_CPC;
        end else if (hit(f.word, MSK_ALU, VAL_MOV)) begin
            d.op = OP_MOV;
        end else if (hit(f.word, MSK_IMM, VAL_CPI) || hit(f.word, MSK_IMM, VAL_LDI)) begin
            d.op = hit(f.word, MSK_IMM, VAL_CPI) ? OP_CPI : OP_LDI;
            d.rd = {1'b1, f.word[7:4]};
        end else if (hit(f.word, MSK_PAIR, VAL_COPY_REG_PAIR)) begin
            d.op = OP_COPY_REG_PAIR;
            d.rd = {f.word[7:4], 1'b0};
            d.rr = {f.word[3:0], 1'b0};
        end else if (hit(f.word, MSK_PAIR, VAL_SKIC) || hit(f.word, MSK_PAIR, VAL_SKIS)) begin
            d.op = hit(f.word, MSK_PAIR, VAL_SKIC) ? OP_SKIC : OP_SKIS;
            d.rr = f.word[7:3];
        end else if (hit(f.word, MSK_SKR, VAL_SKRC)) begin
            d.op = OP_SKRC;
        end else if (hit(f.word, MSK_SKR, VAL_SKRS)) begin
            d.op = OP_SKRS;
        end else if (hit(f.word, MSK_ALU, VAL_BRS)) begin
            d.op = OP_BRS;
        end else if (hit(f.word, MSK_ALU, VAL_BRC)) begin
            d.op = OP_BRC;
        end else if (hit(f.word, MSK_LDST, VAL_LDG)) begin
            d.op = OP_LD;
            case (f.word[3:0])
                NIB_DIRECT: d.pmode = PM_DIRECT;
                NIB_X, NIB_XI, NIB_XD: d.rr = PTR_X;
                NIB_YI, NIB_YD: d.rr = PTR_Y;
                NIB_ZI, NIB_ZD: d.rr = PTR_Z;
                default: d.op = OP_NOP;
            endcase
            if (f.word[3:0] inside {NIB_XI, NIB_YI, NIB_ZI}) begin
                d.pmode = PM_INC;
            end else if (f.word[3:0] inside {NIB_XD, NIB_YD, NIB_ZD}) begin
                d.pmode = PM_DEC;
            end
            d.two_word = d.pmode == PM_DIRECT;
        end else if (hit(f.word, MSK_LDD, VAL_LDD)) begin
            // plain Y/Z loads are the q = 0 case of this form
            d.op = OP_LD;
            d.pmode = PM_DISP;
            d.rr = f.word[3] ? PTR_Y : PTR_Z;
        end else if (hit(f.word, MSK_LDST, VAL_STG)) begin
            d.op = (f.word[3:0] == NIB_X || f.word[3:0] == NIB_XI) ? OP_ST : OP_NOP;
            d.rr = PTR_X;
            d.pmode = (f.word[3:0] == NIB_XI) ? PM_INC : PM_PLAIN;
        end
        return d;
    endfunction

    // ********************************
    // issue: decode and operand read
    // ********************************
    assign dec_next = decode(instr);
    assign accept = instr_valid && instr_ready;
    assign ra_addr = dec_next.rd;
    assign rb_addr = dec_next.rr;
    assign rc_addr = dec_next.rr | 5'h01;

    cble_regfile #(
        .DEPTH(32),
        .DATA_W(REG_W),
        .AW(REG_AW)
    ) u_regfile (
        .mclk(mclk),
        .rst(rst),
        .rd_en(accept),
        .ra_addr(ra_addr),
        .rb_addr(rb_addr),
        .rc_addr(rc_addr),
        .ra_data(ra_data),
        .rb_data(rb_data),
        .rc_data(rc_data),
        .w0_en(w0_en),
        .w0_addr(w0_addr),
        .w0_data(w0_data),
        .w1_en(w1_en),
        .w1_addr(w1_addr),
        .w1_data(w1_data)
    );

    // ********************************
    // execute: conditions and addresses
    // ********************************
    assign fire = exec_valid_reg && state_reg == ST_RUN;

    // the S position is evaluated live so the signed branches see N xor V
    assign test_bit = (exec_reg.bsel == FLAG_S) ? (status_flags_reg[FLAG_N] ^ status_flags_reg[FLAG_V])
                                                : status_flags_reg[exec_reg.bsel];

    always_comb begin
        br_taken = 1'b0;
        skip_taken = 1'b0;
        case (exec_reg.op)
            OP_BRS: br_taken = test_bit;
            OP_BRC: br_taken = ~test_bit;
            OP_SKRC: skip_taken = ~ra_data[exec_reg.bsel];
            OP_SKRS: skip_taken = ra_data[exec_reg.bsel];
            OP_SKIC: skip_taken = ~io_rdata[exec_reg.bsel];
            OP_SKIS: skip_taken = io_rdata[exec_reg.bsel];
            default: br_taken = 1'b0;
        endcase
    end

    assign is_mem = exec_reg.op == OP_LD || exec_reg.op == OP_ST;
    assign ptr = {rc_data, rb_data};
    assign ptr_inc = ptr + 16'h0001;
    assign ptr_dec = ptr - 16'h0001;

    always_comb begin
        case (exec_reg.pmode)
            PM_DEC: eff_addr = ptr_dec;
            PM_DISP: eff_addr = ptr + {10'h000, exec_reg.disp};
            PM_DIRECT: eff_addr = exec_reg.addr;
            default: eff_addr = ptr;
        endcase
    end

    // no new word is taken while a taken branch, skip or memory access is pending
    always_comb begin
        case (state_reg)
            ST_RUN: instr_ready = !(exec_valid_reg && (br_taken || skip_taken || is_mem));
            ST_WAIT: instr_ready = wait_cnt_reg == 2'h1;
            ST_MEM: instr_ready = 1'b1;
            default: instr_ready = 1'b0;
        endcase
    end

    // ********************************
    // sequencing
    // ********************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_RUN;
            wait_cnt_reg <= 2'h0;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (fire && (br_taken || skip_taken)) begin
                        state_reg <= ST_WAIT;
                        wait_cnt_reg <= (skip_taken && exec_reg.skip_two) ? 2'h2 : 2'h1;
                    end else if (fire && is_mem) begin
                        state_reg <= ST_MEM;
                    end
                end
                ST_WAIT: begin
                    if (wait_cnt_reg == 2'h1) begin
                        state_reg <= ST_RUN;
                    end
                    wait_cnt_reg <= wait_cnt_reg - 2'h1;
                end
                ST_MEM: state_reg <= ST_RUN;
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            exec_valid_reg <= 1'b0;
            exec_reg <= '0;
            io_addr_reg <= '0;
        end else begin
            exec_valid_reg <= accept;
            if (accept) begin
                exec_reg <= dec_next;
                io_addr_reg <= dec_next.rr;
            end
        end
    end

    // fetch pointer moves at issue; taken flow changes add on top of pc + 1
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pc_reg <= PC_RESET;
        end else if (accept) begin
            pc_reg <= pc_reg + (dec_next.two_word ? PC_W'(2) : PC_W'(1));
        end else if (fire && br_taken) begin
            pc_reg <= pc_reg + {{(PC_W - BRANCH_OFFS_W){exec_reg.offs[6]}}, exec_reg.offs};
        end else if (fire && skip_taken) begin
            pc_reg <= pc_reg + (exec_reg.skip_two ? PC_W'(2) : PC_W'(1));
        end
    end

    // ********************************
    // status flags
    // ********************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            status_flags_reg <= STATUS_RESET;
        end else if (fire) begin
            case (exec_reg.op)
                OP_CP: status_flags_reg <= cmp_flags(ra_data, rb_data, 1'b0, 1'b0, status_flags_reg);
                OP_CPC: status_flags_reg <= cmp_flags(ra_data, rb_data, status_flags_reg[FLAG_C], 1'b1,
                                                      status_flags_reg);
                OP_CPI: status_flags_reg <= cmp_flags(ra_data, exec_reg.imm, 1'b0, 1'b0, status_flags_reg);
                default: status_flags_reg <= status_flags_reg;
            endcase
        end
    end

    // ********************************
    // register writes
    // ********************************
    always_comb begin
        w0_en = 1'b0;
        w0_addr = exec_reg.rd;
        w0_data = rb_data;
        w1_en = 1'b0;
        w1_addr = exec_reg.rd | 5'h01;
        w1_data = rc_data;
        if (state_reg == ST_MEM && exec_reg.op == OP_LD) begin
            w0_en = 1'b1;
            w0_data = dmem_rdata;
        end else if (fire) begin
            case (exec_reg.op)
                OP_MOV: w0_en = 1'b1;
                OP_COPY_REG_PAIR: begin
                    w0_en = 1'b1;
                    w1_en = 1'b1;
                end
                OP_LDI: begin
                    w0_en = 1'b1;
                    w0_data = exec_reg.imm;
                end
                OP_LD, OP_ST: begin
                    // pointer write-back happens before the memory cycle
                    w0_en = exec_reg.pmode == PM_INC || exec_reg.pmode == PM_DEC;
                    w1_en = w0_en;
                    w0_addr = exec_reg.rr;
                    w1_addr = exec_reg.rr | 5'h01;
                    w0_data = (exec_reg.pmode == PM_INC) ? ptr_inc[7:0] : ptr_dec[7:0];
                    w1_data = (exec_reg.pmode == PM_INC) ? ptr_inc[15:8] : ptr_dec[15:8];
                end
                default: w0_en = 1'b0;
            endcase
        end
    end

    // ********************************
    // data space port
    // ********************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dmem_reg <= '0;
        end else if (fire && is_mem) begin
            dmem_reg.addr <= eff_addr;
            dmem_reg.wdata <= ra_data;
            dmem_reg.we <= exec_reg.op == OP_ST;
            dmem_reg.re <= exec_reg.op == OP_LD;
        end else begin
            dmem_reg.we <= 1'b0;
            dmem_reg.re <= 1'b0;
        end
    end

    assign pc = pc_reg;
    assign status_flags = status_flags_reg;
    assign io_addr = io_addr_reg;
    assign dmem_req = dmem_reg;
endmodule // cble_core

// ---- testbench/cble_mem_model.sv ----
// data space and I/O space model facing the executor
`timescale 1ns/100ps
module cble_mem_model (
    input wire logic mclk,
    input wire logic [cble_pkg::IO_AW-1:0] io_addr,
    output logic [cble_pkg::REG_W-1:0] io_rdata,
    input wire cble_pkg::cble_dmem_req_t dmem_req,
    output logic [cble_pkg::REG_W-1:0] dmem_rdata
);
    import cble_pkg::*;
    logic [DADDR_W-1:0] ra_reg, wa_reg;
    logic [REG_W-1:0] wd_reg;
    // io register p reads as p times eight
    assign io_rdata = {io_addr, 3'h0};
    // outside a read cycle show the inverse, never a stale byte
    assign dmem_rdata = dmem_req.addr[7:0] ^ (dmem_req.re ? 8'h5A : 8'hA5);
    always_ff @(posedge mclk) begin
        if (dmem_req.re) ra_reg <= dmem_req.addr;
        if (dmem_req.we) wa_reg <= dmem_req.addr;
        if (dmem_req.we) wd_reg <= dmem_req.wdata;
    end
endmodule // cble_mem_model

// ---- testbench/cble_core_monitor.sv ----
// port checker for the compare, branch and load/store executor
`timescale 1ns/100ps
module cble_core_monitor #(
    parameter int PC_W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire cble_pkg::cble_fetch_t instr,
    input wire logic instr_ready,
    input wire logic [PC_W-1:0] pc,
    input wire logic [cble_pkg::REG_W-1:0] status_flags,
    input wire cble_pkg::cble_dmem_req_t dmem_req
);
    import cble_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic tk, br, cm, ld, st, hit, pol_reg;
    logic [2:0] sel_reg;
    logic [PC_W-1:0] tgt_reg;
    assign tk = instr_valid && instr_ready;
    assign br = tk && (instr.word & 16'hF800) == VAL_BRS;
    assign cm = tk && ((instr.word & MSK_ALU) inside {VAL_CP, VAL_CPC} || (instr.word & MSK_IMM) == VAL_CPI);
    assign ld = tk && (instr.word & MSK_LDST) == VAL_LDG && instr.word[3:0] == NIB_XI;
    assign st = tk && (instr.word & MSK_LDST) == VAL_STG && instr.word[3:0] == NIB_XI;
    // signed ge/lt read N xor V live, the stored sign bit is never written
    assign hit = ((sel_reg == 3'h4) ? status_flags[2] ^ status_flags[3] : status_flags[sel_reg]) != pol_reg;
    always_ff @(posedge mclk) begin
        if (tk) begin
            tgt_reg <= pc + {{(PC_W-7){instr.word[9]}}, instr.word[9:3]} + 1'b1;
            sel_reg <= instr.word[2:0];
            pol_reg <= instr.word[10];
        end
    end
    sequence br_hit;
        br ##1 !instr_ready;
    endsequence
    flags_cmp_a: assert property ($changed(status_flags) |-> $past(cm, 2))
        else $error("flags moved without a compare");
    br_stall_a: assert property (br |=> instr_ready != hit)
        else $error("branch stall disagrees with flag");
    br_target_a: assert property (br_hit |=> pc == tgt_reg)
        else $error("branch target wrong");
    step_pc_a: assert property (tk && (instr.word & MSK_IMM) == VAL_LDI |=> pc == $past(pc) + 1'b1)
        else $error("pc step wrong");
    ld_pulse_a: assert property (ld |-> ##2 dmem_req.re)
        else $error("load read missing");
    st_pulse_a: assert property (st |-> ##2 dmem_req.we)
        else $error("store write missing");
    re_once_a: assert property (dmem_req.re |=> !dmem_req.re)
        else $error("read longer than one cycle");
    we_once_a: assert property (dmem_req.we |=> !dmem_req.we)
        else $error("write longer than one cycle");
endmodule // cble_core_monitor

// ---- testbench/test_cble_core.sv ----
// self-checking bench for the compare, branch and load/store executor
`timescale 1ns/100ps
module test_cble_core;
    import cble_pkg::*;
    logic mclk = 0, rst = 1, instr_valid = 0, instr_ready;
    cble_fetch_t instr = '0;
    logic [15:0] pc, ep = 16'h0000;
    logic [7:0] status_flags, io_rdata, dmem_rdata;
    logic [4:0] io_addr;
    cble_dmem_req_t dmem_req;
    int n_mismatch = 0, compares = 0;
    always #12.5 mclk = ~mclk;
    cble_core cble_core_i (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .pc(pc), .status_flags(status_flags), .io_addr(io_addr),
        .io_rdata(io_rdata), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));
    cble_mem_model cble_mem_model_i (.mclk(mclk), .io_addr(io_addr), .io_rdata(io_rdata),
        .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // called at a rising edge; returns at the edge that takes the word
    task automatic run(input logic [15:0] w, input logic two = 1'b0);
        // ext mirrors the word so a direct load gets a distinct address
        instr <= '{w, w, two};
        instr_valid <= 1'b1;
        ep = ep + 16'h0001;
        @(negedge mclk);
        for (int i = 0; i < 8 && instr_ready !== 1'b1; i++) @(negedge mclk);
        if (instr_ready !== 1'b1) n_mismatch++;
        @(posedge mclk);
    endtask
    task automatic idle(input int n);
        instr_valid <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_cmp;
        run(16'hE005);
        run(16'h3005);
        run(16'hF019);
        ep = ep + 16'h0003;
        idle(4);
        chk(status_flags, 16'h0002);
        chk(pc, ep);
        $display("compare equal then branch done");
    endtask
    task automatic t_cmp2;
        run(16'h3006);
        run(16'hF428);
        run(16'hF014);
        ep = ep + 16'h0002;
        idle(4);
        chk(status_flags, 16'h0025);
        chk(pc, ep);
        $display("borrow compare then branches done");
    endtask
    task automatic t_skip;
        run(16'hFF01);
        run(16'hFD01);
        ep = ep + 16'h0001;
        idle(4);
        chk(pc, ep);
        run(16'h9B2B, 1'b1);
        ep = ep + 16'h0002;
        idle(5);
        chk(pc, ep);
        chk(status_flags, 16'h0025);
        $display("skips done");
    endtask
    task automatic t_ld;
        run(16'hE1A0);
        run(16'hE0B0);
        run(16'h911D);
        run(16'h931D);
        run(16'h911E);
        idle(4);
        chk(cble_mem_model_i.wa_reg, 16'h0011);
        chk(cble_mem_model_i.wd_reg, 16'h004A);
        chk(cble_mem_model_i.ra_reg, 16'h0011);
        chk(pc, ep);
        $display("pointer load and store done");
    endtask
    task automatic t_mix;
        run(16'hE026);
        run(16'h0720);
        idle(2);
        chk(status_flags, 16'h0000);
        run(16'h01E8);
        run(16'h2F01);
        run(16'h1701);
        run(16'hF408);
        run(16'h9909);
        run(16'h814B);
        ep = ep + 16'h0002;
        idle(4);
        chk(cble_mem_model_i.ra_reg, 16'h4B08);
        run(16'h934C);
        run(16'h9150);
        ep = ep + 16'h0001;
        idle(4);
        chk(cble_mem_model_i.ra_reg, 16'h9150);
        chk(cble_mem_model_i.wd_reg, 16'h0052);
        chk(status_flags, 16'h0002);
        chk(pc, ep);
        $display("moves, carry compare, io skip and direct loads done");
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_cmp();
        t_cmp2();
        t_skip();
        t_ld();
        t_mix();
        conclude();
    end
    // the tests need about seventy cycles; eight hundred leaves ample margin
    initial begin
        #20000;
        n_mismatch++;
        conclude();
    end
endmodule // test_cble_core
bind cble_core cble_core_monitor #(.PC_W(PC_W)) cble_core_monitor_i (.mclk(mclk), .rst(rst),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .pc(pc),
    .status_flags(status_flags), .dmem_req(dmem_req));
